/* File: bpm_dmatch.sv */
`timescale 1ns/1ps
`default_nettype none
module bpm_dmatch
   import bpm_pkg::*;
(
   input  wire bpm_acc_t   acc_i,
   input  wire bpm_dcfg_t  cfg_i,
   output logic            hit_o
);
   logic sel;
   logic a_ok;
   logic v_ok;

   always_comb begin
      sel  = acc_i.valid &&
             (acc_i.store ? cfg_i.store_select : cfg_i.load_select);
      a_ok = bpm_range_hit(acc_i.addr, cfg_i.low, cfg_i.high,
                           cfg_i.addr_sense);
      // all-zero mask gives an equal compare; software must avoid it
      v_ok = (((acc_i.data & cfg_i.mask) ==
               (cfg_i.value & cfg_i.mask)) != cfg_i.value_sense);
      case (cfg_i.mode)
         BPM_MODE_ADDR:  hit_o = sel && a_ok;
         BPM_MODE_VALUE: hit_o = sel && v_ok;
         BPM_MODE_BOTH:  hit_o = sel && a_ok && v_ok;
         default:        hit_o = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

/* File: bpm_map.svh */
`ifndef BPM_MAP_SVH
`define BPM_MAP_SVH
// ============================================================
// register offsets from the mapped io base
`define BPM_OFF_ICTL     24'h101020
`define BPM_OFF_ILOW     24'h101024
`define BPM_OFF_IHIGH    24'h101028
`define BPM_OFF_DCTL     24'h10102c
`define BPM_OFF_DLOW     24'h101030
`define BPM_OFF_DHIGH    24'h101034
`define BPM_OFF_DVAL     24'h101038
`define BPM_OFF_DMASK    24'h10103c
`define BPM_OFF_TCTL     24'h101040
`define BPM_OFF_TMOD     24'h101044
`define BPM_OFF_TVAL     24'h101048
// ============================================================
// field positions
`define BPM_ICTL_EN      0
`define BPM_ICTL_SENSE   1
`define BPM_DCTL_MODE_LO 0
`define BPM_DCTL_MODE_HI 1
`define BPM_DCTL_LOAD    2
`define BPM_DCTL_STORE   3
`define BPM_DCTL_ASENSE  4
`define BPM_DCTL_VSENSE  5
`define BPM_TCTL_RUN     0
`define BPM_TCTL_SRC     1
// ============================================================
// reset values
`define BPM_RST_CTL      32'h0000_0000
`define BPM_RST_WORD     32'h0000_0000
`endif

/* File: bpm_pipe_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// pipeline stand-in: one issue slot and two load/store slots
module bpm_pipe_model
   import bpm_pkg::*;
(
   input  wire logic        mclk_i,
   output var logic         iss_valid_o,
   output var logic [31:0]  iss_addr_o,
   output var bpm_acc_t     acc0_o,
   output var bpm_acc_t     acc1_o
);
   initial begin
      iss_valid_o = 1'b0;
      iss_addr_o  = 32'h0000_0000;
      acc0_o      = '0;
      acc1_o      = '0;
   end
   // released slots carry inverted junk, so stale values never match
   task automatic issue(input logic [31:0] a);
      @(posedge mclk_i);
      iss_valid_o <= 1'b1;
      iss_addr_o  <= a;
      @(posedge mclk_i);
      iss_valid_o <= 1'b0;
      iss_addr_o  <= ~a;
   endtask
   task automatic access(input bpm_acc_t a0, input bpm_acc_t a1);
      @(posedge mclk_i);
      acc0_o <= a0;
      acc1_o <= a1;
      @(posedge mclk_i);
      acc0_o <= '{1'b0, ~a0.store, ~a0.addr, ~a0.data};
      acc1_o <= '{1'b0, ~a1.store, ~a1.addr, ~a1.data};
   endtask
endmodule
`default_nettype wire

/* File: bpm_pkg.sv */
`default_nettype none
package bpm_pkg;
   // ============================================================
   // data break modes
   typedef enum logic [1:0] {
      BPM_MODE_OFF   = 2'h0,
      BPM_MODE_ADDR  = 2'h1,
      BPM_MODE_VALUE = 2'h2,
      BPM_MODE_BOTH  = 2'h3
   } bpm_mode_t;

   // one load/store access from the pipeline
   typedef struct packed {
      logic        valid;
      logic        store;
      logic [31:0] addr;
      logic [31:0] data;
   } bpm_acc_t;

   // data matcher configuration
   typedef struct packed {
      bpm_mode_t   mode;
      logic        load_select;
      logic        store_select;
      logic        addr_sense;
      logic        value_sense;
      logic [31:0] low;
      logic [31:0] high;
      logic [31:0] value;
      logic [31:0] mask;
   } bpm_dcfg_t;

   // complete state of the top module
   typedef struct packed {
      logic        instr_break_enable;
      logic        instr_range_sense;
      logic [31:0] ilow;
      logic [31:0] ihigh;
      bpm_dcfg_t   dcfg;
      logic        tmr_run;
      logic        tmr_src;
      logic [31:0] tmr_mod;
      logic [31:0] tmr_val;
      logic        ievt;
      logic [1:0]  devt;
      logic        irq;
      logic [31:0] rdata;
   } bpm_state_t;

   // inclusive range, or its complement when sense is set
   function automatic logic bpm_range_hit(input logic [31:0] a,
                                          input logic [31:0] lo,
                                          input logic [31:0] hi,
                                          input logic        sense);
      logic in_rng;
      in_rng = (lo <= a) && (a <= hi);
      return sense ? !in_rng : in_rng;
   endfunction
endpackage
`default_nettype wire

/* File: bpm_top.sv */
// What this block does
// - instruction matching runs only while the instruction enable bit is one.
// - reset clears the instruction break control register.
// - instruction range bounds have no defined value until written.
// - every issued instruction address is checked against both bounds.
// - sense zero matches inside the inclusive range, one matches outside.
// - each instruction match yields one countable event to the timer.
// - reset clears the data break control register.
// - data bounds, compare value and mask are undefined until written.
// - data matching is active whenever the mode field is nonzero.
// - modes one and three compare selected load and store addresses.
// - data address sense zero means inside the range, one outside.
// - modes two and three compare selected load and store data.
// - only bits set in the mask take part in the value compare.
// - value sense zero needs equality, one needs a difference.
// - each data match yields an event the timer can count.
// - mode three needs address and value hits on the same access.
// - both accesses per cycle are checked, up to two events a cycle.
// - a data-event timer advances by zero, one or two per cycle.
// - reaching the modulus wraps to zero or one and raises interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "bpm_map.svh"
module bpm_top
   import bpm_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   input  wire logic        iss_valid_i,
   input  wire logic [31:0] iss_addr_i,
   input  wire bpm_acc_t    acc0_i,
   input  wire bpm_acc_t    acc1_i,
   input  wire logic [23:0] mmio_addr_i,
   input  wire logic        mmio_wr_i,
   input  wire logic [31:0] mmio_wdata_i,
   input  wire logic        mmio_rd_i,
   output logic [31:0]      mmio_rdata_o,
   output logic             instr_match_event_o,
   output logic [1:0]       data_match_event_o,
   output logic             timer_irq_o
);
   // ============================================================
   // state
   bpm_state_t r_reg;
   bpm_state_t r_next;
   logic [1:0] dhit;
   logic       ihit;
   logic [1:0] inc;
   logic [32:0] sum;
   logic [32:0] mod33;
   logic        wrap;
   logic        twr;

   assign mmio_rdata_o        = r_reg.rdata;
   assign instr_match_event_o = r_reg.ievt;
   assign data_match_event_o  = r_reg.devt;
   assign timer_irq_o         = r_reg.irq;

   // ============================================================
   // data matchers, one per load/store slot
   bpm_dmatch u_dm0 (
      .acc_i (acc0_i),
      .cfg_i (r_reg.dcfg),
      .hit_o (dhit[0])
   );
   bpm_dmatch u_dm1 (
      .acc_i (acc1_i),
      .cfg_i (r_reg.dcfg),
      .hit_o (dhit[1])
   );

   // ============================================================
   // next state
   always_comb begin
      r_next = r_reg;
      ihit = iss_valid_i && r_reg.instr_break_enable &&
             bpm_range_hit(iss_addr_i, r_reg.ilow, r_reg.ihigh,
                           r_reg.instr_range_sense);
      r_next.ievt = ihit;
      r_next.devt = {1'b0, dhit[0]} + {1'b0, dhit[1]};

      // timer counts last cycle's events so its input is a flop
      inc   = r_reg.tmr_src ? {1'b0, r_reg.ievt} : r_reg.devt;
      // a zero modulus behaves as two to the thirty-second
      mod33 = (r_reg.tmr_mod == 32'h0000_0000) ? 33'h1_0000_0000
                                               : {1'b0, r_reg.tmr_mod};
      sum   = {1'b0, r_reg.tmr_val} + {31'h0000_0000, inc};
      twr   = mmio_wr_i && (mmio_addr_i == `BPM_OFF_TVAL ||
                            mmio_addr_i == `BPM_OFF_TMOD);
      // a value already at or past the modulus counts on with no wrap and no interrupt
      wrap  = r_reg.tmr_run && ({1'b0, r_reg.tmr_val} < mod33) &&
              (sum >= mod33);
      r_next.irq = 1'b0;
      if (r_reg.tmr_run && !twr) begin
         if (wrap) begin
            r_next.tmr_val = 32'(sum - mod33);
            r_next.irq     = 1'b1;
         end else begin
            r_next.tmr_val = sum[31:0];
         end
      end

      if (mmio_wr_i) begin
         case (mmio_addr_i)
            `BPM_OFF_ICTL: begin
               r_next.instr_break_enable = mmio_wdata_i[`BPM_ICTL_EN];
               r_next.instr_range_sense  = mmio_wdata_i[`BPM_ICTL_SENSE];
            end
            `BPM_OFF_ILOW:  r_next.ilow  = mmio_wdata_i;
            `BPM_OFF_IHIGH: r_next.ihigh = mmio_wdata_i;
            `BPM_OFF_DCTL: begin
               r_next.dcfg.mode = bpm_mode_t'(mmio_wdata_i[
                  `BPM_DCTL_MODE_HI:`BPM_DCTL_MODE_LO]);
               r_next.dcfg.load_select  = mmio_wdata_i[`BPM_DCTL_LOAD];
               r_next.dcfg.store_select = mmio_wdata_i[`BPM_DCTL_STORE];
               r_next.dcfg.addr_sense   = mmio_wdata_i[`BPM_DCTL_ASENSE];
               r_next.dcfg.value_sense  = mmio_wdata_i[`BPM_DCTL_VSENSE];
            end
            `BPM_OFF_DLOW:  r_next.dcfg.low   = mmio_wdata_i;
            `BPM_OFF_DHIGH: r_next.dcfg.high  = mmio_wdata_i;
            `BPM_OFF_DVAL:  r_next.dcfg.value = mmio_wdata_i;
            `BPM_OFF_DMASK: r_next.dcfg.mask  = mmio_wdata_i;
            `BPM_OFF_TCTL: begin
               r_next.tmr_run = mmio_wdata_i[`BPM_TCTL_RUN];
               r_next.tmr_src = mmio_wdata_i[`BPM_TCTL_SRC];
            end
            `BPM_OFF_TMOD:  r_next.tmr_mod = mmio_wdata_i;
            `BPM_OFF_TVAL:  r_next.tmr_val = mmio_wdata_i;
            default: ;
         endcase
      end

      if (mmio_rd_i) begin
         case (mmio_addr_i)
            `BPM_OFF_ICTL:  r_next.rdata = {30'h0000_0000,
                               r_reg.instr_range_sense,
                               r_reg.instr_break_enable};
            `BPM_OFF_ILOW:  r_next.rdata = r_reg.ilow;
            `BPM_OFF_IHIGH: r_next.rdata = r_reg.ihigh;
            `BPM_OFF_DCTL:  r_next.rdata = {26'h000_0000,
                               r_reg.dcfg.value_sense,
                               r_reg.dcfg.addr_sense,
                               r_reg.dcfg.store_select,
                               r_reg.dcfg.load_select,
                               r_reg.dcfg.mode};
            `BPM_OFF_DLOW:  r_next.rdata = r_reg.dcfg.low;
            `BPM_OFF_DHIGH: r_next.rdata = r_reg.dcfg.high;
            `BPM_OFF_DVAL:  r_next.rdata = r_reg.dcfg.value;
            `BPM_OFF_DMASK: r_next.rdata = r_reg.dcfg.mask;
            `BPM_OFF_TCTL:  r_next.rdata = {30'h0000_0000,
                               r_reg.tmr_src, r_reg.tmr_run};
            `BPM_OFF_TMOD:  r_next.rdata = r_reg.tmr_mod;
            `BPM_OFF_TVAL:  r_next.rdata = r_reg.tmr_val;
            default:        r_next.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ============================================================
   // registers
   // bounds, value and mask are cleared too; software may not rely on it
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // ============================================================
   // checks
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   a_ctl_after_reset: assert property (
      disable iff (1'b0)
      $fell(rst_i) |-> !r_reg.instr_break_enable &&
                       r_reg.dcfg.mode == BPM_MODE_OFF)
      else $error("control not cleared by reset");

   a_instr_off_quiet: assert property (
      !r_reg.instr_break_enable |=> !instr_match_event_o)
      else $error("instruction event while disabled");

   a_instr_hit_pulse: assert property (
      iss_valid_i && r_reg.instr_break_enable &&
      bpm_range_hit(iss_addr_i, r_reg.ilow, r_reg.ihigh,
                    r_reg.instr_range_sense)
      |=> instr_match_event_o)
      else $error("instruction match missed");

   a_instr_no_hit: assert property (
      !(iss_valid_i && ihit) |=> !instr_match_event_o)
      else $error("spurious instruction event");

   a_data_off_quiet: assert property (
      r_reg.dcfg.mode == BPM_MODE_OFF |=> data_match_event_o == 2'h0)
      else $error("data event while disabled");

   a_data_count_two: assert property (
      dhit == 2'h3 |=> data_match_event_o == 2'h2)
      else $error("data event count wrong");

   a_data_count_one: assert property (
      dhit == 2'h1 || dhit == 2'h2 |=> data_match_event_o == 2'h1)
      else $error("single data event count wrong");

   a_data_count_none: assert property (
      dhit == 2'h0 |=> data_match_event_o == 2'h0)
      else $error("data event without a hit");

   a_both_needs_addr: assert property (
      r_reg.dcfg.mode == BPM_MODE_BOTH &&
      !bpm_range_hit(acc0_i.addr, r_reg.dcfg.low, r_reg.dcfg.high,
                     r_reg.dcfg.addr_sense)
      |-> !dhit[0])
      else $error("mode three hit without address match");

   a_masked_equal: assert property (
      r_reg.dcfg.mode == BPM_MODE_VALUE && acc0_i.valid &&
      !acc0_i.store && r_reg.dcfg.load_select &&
      !r_reg.dcfg.value_sense &&
      ((acc0_i.data ^ r_reg.dcfg.value) & r_reg.dcfg.mask) == 32'h0
      |=> data_match_event_o != 2'h0)
      else $error("masked value match missed");

   a_store_unselected: assert property (
      acc0_i.store && !r_reg.dcfg.store_select |-> !dhit[0])
      else $error("store matched while not selected");

   a_timer_step: assert property (
      r_reg.tmr_run && !twr && !wrap
      |=> r_reg.tmr_val == $past(sum[31:0]) && !timer_irq_o)
      else $error("timer step wrong");

   a_timer_wrap: assert property (
      r_reg.tmr_run && !twr && wrap
      |=> timer_irq_o && r_reg.tmr_val < 32'h0000_0002)
      else $error("timer wrap wrong");

   // a store to value or modulus never raises the interrupt itself
   a_timer_write_quiet: assert property (
      twr |=> !timer_irq_o)
      else $error("timer interrupt on a register store");
endmodule
`default_nettype wire

/* File: tb_breakpoint_match_unit.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bpm_map.svh"
module tb_breakpoint_match_unit
   import bpm_pkg::*;
;
   logic        mclk_i;
   logic        rst_i;
   logic [23:0] maddr;
   logic        mwr;
   logic [31:0] mwdata;
   logic        mrd;
   logic [31:0] mrdata;
   logic        ievt;
   logic [1:0]  devt;
   logic        irq;
   logic        iss_valid;
   logic [31:0] iss_addr;
   bpm_acc_t    acc0;
   bpm_acc_t    acc1;
   int          fail_count;
   int          checks_done;
   logic [31:0] d;
   logic [31:0] ta [4] = '{32'h0000_00ff, 32'h0000_0100,
                           32'h0000_0200, 32'h0000_0201};
   localparam bpm_acc_t NO = '0;

   bpm_pipe_model pipe (.mclk_i(mclk_i), .iss_valid_o(iss_valid),
      .iss_addr_o(iss_addr), .acc0_o(acc0), .acc1_o(acc1));
   bpm_top DUT (.mclk_i(mclk_i), .rst_i(rst_i), .iss_valid_i(iss_valid),
      .iss_addr_i(iss_addr), .acc0_i(acc0), .acc1_i(acc1),
      .mmio_addr_i(maddr), .mmio_wr_i(mwr), .mmio_wdata_i(mwdata),
      .mmio_rd_i(mrd), .mmio_rdata_o(mrdata),
      .instr_match_event_o(ievt), .data_match_event_o(devt),
      .timer_irq_o(irq));

   // ============================================================
   // shared tasks
   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [23:0] a, input logic [31:0] v);
      @(posedge mclk_i);
      maddr  <= a;
      mwdata <= v;
      mwr    <= 1'b1;
      @(posedge mclk_i);
      mwr    <= 1'b0;
   endtask
   task automatic rd(input logic [23:0] a, output logic [31:0] v);
      @(posedge mclk_i);
      maddr <= a;
      mrd   <= 1'b1;
      @(posedge mclk_i);
      mrd   <= 1'b0;
      #1 v = mrdata;
   endtask
   function automatic bpm_acc_t mk(input logic s, input logic [31:0] a,
                                   input logic [31:0] v);
      return '{1'b1, s, a, v};
   endfunction
   // match shows one cycle after the drive edge and only for one cycle
   task automatic ichk(input logic [31:0] a, input logic e);
      pipe.issue(a);
      #1 chk("instr event", 32'(ievt), 32'(e));
      @(posedge mclk_i);
      #1 chk("instr pulse end", 32'(ievt), 32'h0);
   endtask
   task automatic dchk(input bpm_acc_t a0, input bpm_acc_t a1,
                       input logic [1:0] e);
      pipe.access(a0, a1);
      #1 chk("data count", 32'(devt), 32'(e));
      @(posedge mclk_i);
      #1 chk("data count end", 32'(devt), 32'h0);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ============================================================
   // scenarios
   task automatic t_reset();
      rd(`BPM_OFF_ICTL, d);
      chk("instr control", d, 32'h0);
      rd(`BPM_OFF_DCTL, d);
      chk("data control", d, 32'h0);
      rd(24'h101100, d);
      chk("unmapped read", d, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_instr();
      wr(`BPM_OFF_ILOW, 32'h0000_0100);
      wr(`BPM_OFF_IHIGH, 32'h0000_0200);
      ichk(32'h0000_0150, 1'b0);
      wr(`BPM_OFF_ICTL, 32'h0000_0001);
      for (int i = 0; i < 4; i++) ichk(ta[i], i == 1 || i == 2);
      wr(`BPM_OFF_ICTL, 32'h0000_0003);
      for (int i = 0; i < 4; i++) ichk(ta[i], !(i == 1 || i == 2));
      rd(`BPM_OFF_ICTL, d);
      chk("instr control back", d, 32'h0000_0003);
      $display("instr test done");
   endtask
   task automatic t_daddr();
      wr(`BPM_OFF_DLOW, 32'h0000_1000);
      wr(`BPM_OFF_DHIGH, 32'h0000_1fff);
      wr(`BPM_OFF_DCTL, 32'h0000_0005);
      dchk(mk(0, 32'h1000, 0), NO, 2'h1);
      dchk(mk(1, 32'h1000, 0), NO, 2'h0);
      dchk(mk(0, 32'h1fff, 0), mk(0, 32'h1000, 0), 2'h2);
      dchk(mk(0, 32'h2000, 0), NO, 2'h0);
      wr(`BPM_OFF_DCTL, 32'h0000_0019);
      dchk(mk(1, 32'h2000, 0), mk(0, 32'h0fff, 0), 2'h1);
      wr(`BPM_OFF_DCTL, 32'h0000_000c);
      dchk(mk(0, 32'h1000, 0), mk(1, 32'h1000, 0), 2'h0);
      $display("data address test done");
   endtask
   task automatic t_dval();
      wr(`BPM_OFF_DVAL, 32'h0000_1234);
      wr(`BPM_OFF_DMASK, 32'h0000_ff00);
      wr(`BPM_OFF_DCTL, 32'h0000_000e);
      dchk(mk(0, 0, 32'hab12cd), mk(1, 0, 32'h1334), 2'h1);
      wr(`BPM_OFF_DCTL, 32'h0000_002e);
      dchk(mk(0, 0, 32'h1334), mk(1, 0, 32'hff00), 2'h2);
      dchk(mk(0, 0, 32'h0012ff), NO, 2'h0);
      wr(`BPM_OFF_DCTL, 32'h0000_0007);
      dchk(mk(0, 32'h3000, 32'h1200), mk(0, 32'h1000, 32'h1200),
           2'h1);
      dchk(mk(0, 32'h1000, 32'h1300), NO, 2'h0);
      $display("data value test done");
   endtask
   task automatic t_timer();
      wr(`BPM_OFF_DCTL, 32'h0000_0005);
      wr(`BPM_OFF_TMOD, 32'h0000_0003);
      wr(`BPM_OFF_TVAL, 32'h0000_0002);
      wr(`BPM_OFF_TCTL, 32'h0000_0001);
      pipe.access(mk(0, 32'h1000, 0), mk(0, 32'h1004, 0));
      #1 chk("double event", 32'(devt), 32'h2);
      @(posedge mclk_i);
      #1 chk("timer irq", 32'(irq), 32'h1);
      @(posedge mclk_i);
      #1 chk("timer irq end", 32'(irq), 32'h0);
      wr(`BPM_OFF_TCTL, 32'h0000_0000);
      rd(`BPM_OFF_TVAL, d);
      chk("timer wrap value", d, 32'h0000_0001);
      wr(`BPM_OFF_TMOD, 32'h0000_0002);
      wr(`BPM_OFF_TCTL, 32'h0000_0003);
      dchk(mk(0, 32'h1000, 0), NO, 2'h1);
      ichk(32'h0000_0300, 1'b1);
      chk("instr timer irq", 32'(irq), 32'h1);
      rd(`BPM_OFF_TVAL, d);
      chk("instr timer value", d, 32'h0000_0000);
      $display("timer test done");
   endtask
   task automatic t_rereset();
      @(posedge mclk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      rd(`BPM_OFF_ICTL, d);
      chk("instr control cleared", d, 32'h0);
      rd(`BPM_OFF_DCTL, d);
      chk("data control cleared", d, 32'h0);
      ichk(32'h0000_0300, 1'b0);
      $display("second reset test done");
   endtask

   // ============================================================
   // clock, reset, sequence and watchdog
   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end
   initial begin
      rst_i       = 1'b1;
      maddr       = 24'h000000;
      mwr         = 1'b0;
      mwdata      = 32'h0000_0000;
      mrd         = 1'b0;
      fail_count  = 0;
      checks_done = 0;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      t_reset();
      t_instr();
      t_daddr();
      t_dval();
      t_timer();
      t_rereset();
      final_report();
   end
   // a hang counts as a mismatch and still reaches the verdict
   initial begin
      repeat (20000) @(posedge mclk_i);
      fail_count++;
      final_report();
   end
endmodule
`default_nettype wire
